// *** design/flash_prog_ctrl.v ***
// Flash self-programming sequencer, lock setting and parallel fuse high byte write
`timescale 1ns/1ps
`include "flash_prog_regs.vh"

module flash_prog_ctrl #(
  parameter PAGE_OP_CYCLES = `PAGE_OP_CYC
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output wire irq_o,
  // CPU side
  input wire store_program_instr_i,
  input wire eeprom_busy_i,
  input wire [`PAGE_BITS-1:0] fetch_page_i,
  output wire cpu_halt_o,
  output wire rww_read_ok_o,
  output wire no_read_while_write_section_read_ok_o,
  output wire spm_irq_o,
  // Parallel programmer
  input wire pp_mode_i,
  input wire [7:0] pp_data_i,
  input wire pp_xa_cmd_i,
  input wire pp_xa_data_i,
  input wire byte_select_high_pin_i,
  input wire byte_select_low_pin_i,
  input wire pp_wr_n_i,
  output reg ready_busy_pin_o,
  output wire [7:0] fuse_high_o,
  output wire [7:0] lock_bits_o
);

  localparam S_IDLE = 2'h0;
  localparam S_PAGE = 2'h1;
  localparam S_LOCK = 2'h2;
  localparam [31:0] PAGE_CYC = PAGE_OP_CYCLES;
  localparam [31:0] LOCK_CYC = `LOCK_OP_CYC;
  localparam [31:0] FUSE_CYC = `FUSE_OP_CYC;

  // ============================================================
  // Registers
  reg [7:0] ctrl_q;
  reg [15:0] pointer_q;
  reg [7:0] lockdata_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  reg [7:0] lock_q;
  reg [7:0] fuse_q;
  reg [1:0] state_q;
  reg [31:0] op_cnt_q;
  reg [2:0] window_q;
  reg section_busy_q;
  reg halt_q;
  reg [`PAGE_BITS-1:0] op_page_q;
  reg [7:0] pp_cmd_q;
  reg [7:0] pp_dat_q;
  reg pp_wr_n_q;
  reg [31:0] fuse_cnt_q;
  reg [7:0] ctrl_d;
  reg [2:0] window_d;
  reg [2:0] irq_stat_d;
  reg [31:0] rd_data_d;

  wire bus_req;
  wire bus_wr;
  wire [`PAGE_BITS-1:0] ptr_page;
  wire op_done;
  wire spm_armed;
  wire spm_go;
  wire is_lock;
  wire is_page;
  wire boot_locked;
  wire page_reject;
  wire page_start;
  wire lock_start;
  wire target_no_read_while_write_section;
  wire fuse_strobe;
  wire fuse_go;
  wire ev_done;
  wire ev_reject;
  wire ev_fuse;
  wire [2:0] events;
  wire reenable_wr;
  wire [5:0] lock_next;

  // ============================================================
  // Request decode
  assign bus_req = cyc_i & stb_i & ~ack_o;
  // Writes land on the edge that samples ack, as the master expects
  assign bus_wr = cyc_i & stb_i & ack_o & we_i & sel_i[0];
  assign ptr_page = pointer_q[`PAGE_MSB:`PAGE_LSB];
  assign op_done = (state_q != S_IDLE) && (op_cnt_q == 32'h1);
  assign spm_armed = ctrl_q[`CTRL_ENABLE] & (window_q != 3'h0);
  assign spm_go = spm_armed & store_program_instr_i & (state_q == S_IDLE);
  assign is_lock = (ctrl_q[6:0] & `CTRL_LOCK_MASK) == `CTRL_LOCK_PATTERN;
  assign is_page = ctrl_q[`CTRL_PAGE_ERASE] | ctrl_q[`CTRL_PAGE_WRITE];
  // Boot section writes refused once its protection bit is programmed (zero)
  assign boot_locked = ~lock_q[`LOCK_BOOT_A1] & (ptr_page >= `BOOT_FIRST_PAGE); // see RL13
  assign page_reject = spm_go & is_page & (boot_locked | eeprom_busy_i); // see RL12
  assign page_start = spm_go & is_page & ~page_reject;
  assign lock_start = spm_go & is_lock & ~eeprom_busy_i; // see RL12
  assign target_no_read_while_write_section = ptr_page >= `NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE;
  assign fuse_strobe = pp_mode_i & pp_wr_n_q & ~pp_wr_n_i;
  assign fuse_go = fuse_strobe & (pp_cmd_q == `CMD_FUSE_HIGH)
                   & ({byte_select_high_pin_i, byte_select_low_pin_i} == `BS_HIGH_BYTE); // see RL16
  assign ev_done = op_done;
  assign ev_reject = page_reject;
  assign ev_fuse = fuse_cnt_q == 32'h1;
  assign events = {ev_fuse, ev_reject, ev_done};
  assign reenable_wr = bus_wr && (adr_i == `REG_CTRL) && dat_i[`CTRL_REENABLE];

  // ============================================================
  // Lock bit programming, one cell per bit
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_lock
      // Programming only clears bits; nothing here can erase a lock
      assign lock_next[gi] = lock_q[gi] & lockdata_q[gi]; // see RL9
    end
  endgenerate

  // ============================================================
  // Control register and store-program window
  always @* begin
    ctrl_d = ctrl_q;
    window_d = window_q;
    if (bus_wr && (adr_i == `REG_CTRL) && !(eeprom_busy_i && dat_i[`CTRL_ENABLE])) begin
      ctrl_d = {dat_i[7], 2'h0, 1'b0, dat_i[3:0]}; // see RL12
      window_d = dat_i[`CTRL_ENABLE] ? `SPM_WINDOW_CYC : 3'h0;
    end else begin
      if (op_done || spm_go || (window_q == 3'h1 && state_q == S_IDLE)) begin
        ctrl_d[3:0] = 4'h0; // see RL19
      end
      if (window_q != 3'h0) begin
        window_d = spm_go ? 3'h0 : window_q - 3'h1; // see RL8
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= 8'h00;
      window_q <= 3'h0;
    end else begin
      ctrl_q <= ctrl_d;
      window_q <= window_d;
    end
  end

  // ============================================================
  // Pointer, lock data, mask registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      pointer_q <= 16'h0000;
      lockdata_q <= 8'hFF;
      irq_mask_q <= 3'h0;
    end else if (bus_wr) begin
      case (adr_i)
        `REG_POINTER: pointer_q <= dat_i[15:0]; // see RL1
        `REG_LOCKDATA: lockdata_q <= dat_i[7:0];
        `REG_IRQ_MASK: irq_mask_q <= dat_i[2:0];
        default: pointer_q <= pointer_q;
      endcase
    end
  end

  // ============================================================
  // Operation sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      op_cnt_q <= 32'h0;
      op_page_q <= {`PAGE_BITS{1'b0}};
      lock_q <= `LOCK_RESET;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (page_start) begin
            state_q <= S_PAGE;
            op_cnt_q <= PAGE_CYC;
            op_page_q <= ptr_page;
          end else if (lock_start) begin
            state_q <= S_LOCK;
            op_cnt_q <= LOCK_CYC;
          end
        end
        S_PAGE: begin
          op_cnt_q <= op_cnt_q - 32'h1;
          if (op_done) begin
            state_q <= S_IDLE;
          end
        end
        S_LOCK: begin
          op_cnt_q <= op_cnt_q - 32'h1;
          if (op_done) begin
            state_q <= S_IDLE;
            lock_q[5:0] <= lock_next; // see RL9
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ============================================================
  // Section busy flag, a starting page operation wins over the re-enable write
  always @(posedge clk_i) begin
    if (rst_i) begin
      section_busy_q <= 1'b0;
    end else if (page_start) begin
      section_busy_q <= 1'b1; // see RL6
    end else if (reenable_wr && state_q == S_IDLE) begin
      // Held past completion until software re-enables
      section_busy_q <= 1'b0; // see RL7
    end
  end

  // ============================================================
  // Processor halt for page operations on the no-read-while-write pages
  always @(posedge clk_i) begin
    if (rst_i) begin
      halt_q <= 1'b0;
    end else if (page_start) begin
      halt_q <= target_no_read_while_write_section; // see RL3
    end else if (state_q == S_PAGE && op_done) begin
      halt_q <= 1'b0;
    end
  end

  // ============================================================
  // Interrupt status, set wins over write-one-to-clear
  always @* begin
    irq_stat_d = irq_stat_q | events;
    if (bus_wr && adr_i == `REG_IRQ_STATUS) begin
      irq_stat_d = (irq_stat_q & ~dat_i[2:0]) | events;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= 3'h0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // ============================================================
  // Interrupt and status outputs

  assign irq_o = |(irq_stat_q & irq_mask_q);
  assign spm_irq_o = ctrl_q[`CTRL_IRQ_EN] & ~ctrl_q[`CTRL_ENABLE]; // see RL4
  assign cpu_halt_o = halt_q; // see RL3
  // Lock programming leaves all reads open; page ops close the busy section
  assign rww_read_ok_o = ~section_busy_q; // see RL5
  assign no_read_while_write_section_read_ok_o = ~halt_q; // see RL2 RL11
  assign lock_bits_o = lock_q;
  assign fuse_high_o = fuse_q;

  // ============================================================
  // Parallel programming: command, data, write strobe, ready/busy
  always @(posedge clk_i) begin
    if (rst_i) begin
      pp_cmd_q <= 8'h00;
      pp_dat_q <= 8'hFF;
    end else begin
      if (pp_mode_i && pp_xa_cmd_i) begin
        pp_cmd_q <= pp_data_i; // see RL14
      end
      if (pp_mode_i && pp_xa_data_i) begin
        pp_dat_q <= pp_data_i;
      end
    end
  end

  // Strobe history idles high, so reset leaves no false falling edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      pp_wr_n_q <= 1'b1;
    end else begin
      pp_wr_n_q <= pp_wr_n_i;
    end
  end

  // Strobes arriving while busy are ignored
  always @(posedge clk_i) begin
    if (rst_i) begin
      fuse_cnt_q <= 32'h0;
      fuse_q <= `FUSE_RESET;
      ready_busy_pin_o <= 1'b1;
    end else if (fuse_go && fuse_cnt_q == 32'h0) begin
      fuse_cnt_q <= FUSE_CYC;
      ready_busy_pin_o <= 1'b0; // see RL17
    end else if (fuse_cnt_q != 32'h0) begin
      fuse_cnt_q <= fuse_cnt_q - 32'h1;
      if (fuse_cnt_q == 32'h1) begin
        fuse_q <= pp_dat_q; // see RL15
        ready_busy_pin_o <= 1'b1;
      end
    end
  end

  // ============================================================
  // Read data selection
  always @* begin
    case (adr_i)
      `REG_CTRL: rd_data_d = {24'h0, ctrl_q[7], 1'b0, section_busy_q, 1'b0, ctrl_q[3:0]};
      `REG_POINTER: rd_data_d = {16'h0, pointer_q};
      `REG_LOCKDATA: rd_data_d = {24'h0, lockdata_q};
      `REG_STATUS: rd_data_d = {28'h0, state_q == S_LOCK, halt_q, section_busy_q, state_q != S_IDLE};
      `REG_IRQ_STATUS: rd_data_d = {29'h0, irq_stat_q};
      `REG_IRQ_MASK: rd_data_d = {29'h0, irq_mask_q};
      // Fuse and lock reads blanked during EEPROM write
      `REG_LOCKBITS: rd_data_d = eeprom_busy_i ? 32'h0 : {24'h0, lock_q}; // see RL12
      `REG_FUSE_HIGH: rd_data_d = eeprom_busy_i ? 32'h0 : {24'h0, fuse_q}; // see RL12
      default: rd_data_d = 32'h0000_0000;
    endcase
  end

  // ============================================================
  // Wishbone ack and registered read data; answer one cycle after request
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        dat_o <= rd_data_d;
      end
    end
  end

endmodule

// *** pkg/flash_prog_regs.vh ***
// Register offsets, field positions, reset values and timing counts for the flash programming controller
// Overview of operation
// RL1 - Software puts page number in page address field, other pointer bits zero.
// RL2 - Page write to read-while-write section keeps other section readable.
// RL3 - Page write to no-read-while-write section halts the processor until done.
// RL4 - Enabled self-program interrupt stays asserted while store-program enable is clear.
// RL5 - Any page erase or write blocks reads of read-while-write section.
// RL6 - Section busy flag stays set while read-while-write section is occupied.
// RL7 - Writing section read re-enable clears busy flag and restores read access.
// RL8 - Lock set: load first register, write X0001001, store-program within four cycles.
// RL9 - Zero bits 5..0 of lock data program lock bits if store-program is timely.
// RL10 - Pointer ignored during lock setting; software keeps top lock data bits one.
// RL11 - Whole program memory stays readable while lock bits are programmed.
// RL12 - EEPROM write blocks software programming and software fuse or lock reads.
// RL13 - Programmed boot lock bit rejects software writes to boot loader section.
// RL14 - Programmer loads command 0100 0000 to write the high fuse byte.
// RL15 - Data bit 0 programs a fuse bit, data bit 1 erases it.
// RL16 - Byte-select pins at 01 select the high data byte before the strobe.
// RL17 - One low write pulse; ready/busy held low until fuse write completes.
// RL18 - Programmer returns byte-select pins to 00 afterwards.
// RL19 - Enable and lock-set request self-clear without store-program within four cycles.
`ifndef FLASH_PROG_REGS_VH
`define FLASH_PROG_REGS_VH

// ============================================================
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_POINTER 8'h04
`define REG_LOCKDATA 8'h08
`define REG_STATUS 8'h0C
`define REG_IRQ_STATUS 8'h10
`define REG_IRQ_MASK 8'h14
`define REG_LOCKBITS 8'h18
`define REG_FUSE_HIGH 8'h1C

// ============================================================
// Control register fields
`define CTRL_ENABLE 0
`define CTRL_PAGE_ERASE 1
`define CTRL_PAGE_WRITE 2
`define CTRL_LOCK_SET 3
`define CTRL_REENABLE 4
`define CTRL_IRQ_EN 7
`define CTRL_LOCK_PATTERN 7'h09
`define CTRL_LOCK_MASK 7'h7F

// ============================================================
// Pointer layout, lock bit positions
`define PAGE_LSB 7
`define PAGE_MSB 14
`define PAGE_BITS 8
`define NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE 8'hE0
`define BOOT_FIRST_PAGE 8'hF0
`define LOCK_BOOT_A1 4

// ============================================================
// Status register and interrupt event positions
`define ST_BUSY 0
`define ST_SECTION_BUSY 1
`define ST_HALT 2
`define ST_LOCK_ACTIVE 3
`define EV_DONE 0
`define EV_REJECT 1
`define EV_FUSE_DONE 2

// ============================================================
// Reset values
`define LOCK_RESET 8'hFF
`define FUSE_RESET 8'hFF

// ============================================================
// Timing: window and operation times at 125 MHz
`define SPM_WINDOW_CYC 3'h4
`define CLK_PERIOD_NS 8
`define PAGE_OP_NS 4500000
`define LOCK_OP_NS 4500
`define FUSE_OP_NS 4500
`define PAGE_OP_CYC ((`PAGE_OP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCK_OP_CYC ((`LOCK_OP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FUSE_OP_CYC ((`FUSE_OP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ============================================================
// Parallel programming command
`define CMD_FUSE_HIGH 8'h40
`define BS_HIGH_BYTE 2'h1

`endif

// *** bench/flash_prog_asserts.sv ***
// Port-level checks for the flash programming controller
`timescale 1ns/1ps
module flash_prog_asserts (
  // Clock, reset and bus
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire ack_o,
  // Status outputs
  input wire cpu_halt_o,
  input wire rww_read_ok_o,
  input wire no_read_while_write_section_read_ok_o,
  input wire spm_irq_o,
  input wire ready_busy_pin_o,
  input wire [7:0] lock_bits_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire ctrl_wr = cyc_i && stb_i && we_i && sel_i[0] && adr_i == 8'h00;
  wire reen_wr = ctrl_wr && dat_i[4];
  sequence irq_en_wr;
    ctrl_wr && dat_i[7] && !dat_i[0];
  endsequence
  sequence fuse_busy;
    !ready_busy_pin_o [*8];
  endsequence
  chk_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  chk_irq_level: assert property (irq_en_wr |-> ##[1:3] spm_irq_o)
    else $error("spm irq not raised");
  chk_halt_blocks: assert property (cpu_halt_o |-> !no_read_while_write_section_read_ok_o) else $error("halt readable");
  chk_rww_blocked: assert property (cpu_halt_o |-> !rww_read_ok_o) else $error("rww readable");
  chk_busy_holds: assert property ($fell(rww_read_ok_o) |-> !rww_read_ok_o [*8])
    else $error("busy flag dropped");
  chk_reenable_only: assert property ($rose(rww_read_ok_o) |-> $past(reen_wr) || $past(reen_wr, 2))
    else $error("rww back without reenable");
  chk_rdy_holds: assert property ($fell(ready_busy_pin_o) |-> fuse_busy) else $error("rdy glitch");
  chk_rdy_returns: assert property ($fell(ready_busy_pin_o) |-> ##[550:580] ready_busy_pin_o)
    else $error("rdy late");
  chk_lock_readable: assert property ($changed(lock_bits_o) |-> rww_read_ok_o && no_read_while_write_section_read_ok_o)
    else $error("lock op blocked reads");
endmodule
bind flash_prog_ctrl flash_prog_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .cpu_halt_o(cpu_halt_o),
  .rww_read_ok_o(rww_read_ok_o), .no_read_while_write_section_read_ok_o(no_read_while_write_section_read_ok_o), .spm_irq_o(spm_irq_o),
  .ready_busy_pin_o(ready_busy_pin_o), .lock_bits_o(lock_bits_o));

// *** bench/par_programmer.sv ***
// Parallel programmer model for the fuse high byte write
`timescale 1ns/1ps
module par_programmer (
  // Clock and device status
  input wire clk_i,
  input wire ready_busy_pin_i,
  // Programming pins
  output logic mode_o = 1'b0,
  output logic [7:0] data_o = 8'h00,
  output logic xa_cmd_o = 1'b0,
  output logic xa_data_o = 1'b0,
  output logic bs_high_o = 1'b0,
  output logic bs_low_o = 1'b0,
  output logic wr_n_o = 1'b1
);
  task automatic write_fuse(input logic [7:0] d, output int waited);
    waited = 0;
    mode_o <= 1'b1;
    data_o <= 8'h40;
    xa_cmd_o <= 1'b1;
    @(posedge clk_i);
    xa_cmd_o <= 1'b0;
    data_o <= d;
    xa_data_o <= 1'b1;
    @(posedge clk_i);
    xa_data_o <= 1'b0;
    // Stale data is not kept on the bus
    data_o <= ~d;
    bs_low_o <= 1'b1;
    @(posedge clk_i);
    wr_n_o <= 1'b0;
    @(posedge clk_i);
    wr_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    while (ready_busy_pin_i !== 1'b1 && waited < 2000) begin
      @(posedge clk_i);
      waited++;
    end
    bs_low_o <= 1'b0;
  endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking testbench for the flash programming controller
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module testbench;
  // ============================================================
  // Signals and instances
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, store_program_instr_i = 1'b0, eeprom_busy_i = 1'b0;
  logic [7:0] adr_i = 8'h00, fetch_page_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, rd;
  wire [31:0] dat_o;
  wire ack_o, irq_o, cpu_halt_o, rww_read_ok_o, no_read_while_write_section_read_ok_o, spm_irq_o, ready_busy_pin_o;
  wire pp_mode_i, pp_xa_cmd_i, pp_xa_data_i, byte_select_high_pin_i, byte_select_low_pin_i, pp_wr_n_i;
  wire [7:0] pp_data_i, fuse_high_o, lock_bits_o;
  int miscompares = 0, n_checks = 0, waited;
  localparam int OP = 20;
  flash_prog_ctrl #(.PAGE_OP_CYCLES(OP)) DUT (.*);
  par_programmer u_pp (.clk_i(clk_i), .ready_busy_pin_i(ready_busy_pin_o), .mode_o(pp_mode_i),
    .data_o(pp_data_i), .xa_cmd_o(pp_xa_cmd_i), .xa_data_o(pp_xa_data_i), .bs_high_o(byte_select_high_pin_i),
    .bs_low_o(byte_select_low_pin_i), .wr_n_o(pp_wr_n_i));
  initial forever #4 clk_i = ~clk_i;
  // ============================================================
  // Bus and CPU tasks
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    @(negedge clk_i);
    while (ack_o !== 1'b1 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 50) miscompares++;
    rd = dat_o;
    @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic store_program_instr;
    store_program_instr_i <= 1'b1;
    @(posedge clk_i);
    store_program_instr_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // ============================================================
  // Scenarios
  task automatic t_spm_irq;
    rdchk(8'h18, 32'hFF);
    rdchk(8'h1C, 32'hFF);
    rdchk(8'h20, 32'h0);
    wb(1'b1, 8'h00, 32'h80);
    `CHK(spm_irq_o, 1'b1)
    wb(1'b1, 8'h00, 32'h81);
    `CHK(spm_irq_o, 1'b0)
    repeat (6) @(posedge clk_i);
    rdchk(8'h00, 32'h80);
    `CHK(spm_irq_o, 1'b1)
    wb(1'b1, 8'h00, 32'h0);
  endtask
  task automatic t_page(input logic [7:0] pg, input logic halt);
    wb(1'b1, 8'h04, {17'h0, pg, 7'h0});
    wb(1'b1, 8'h00, 32'h05);
    store_program_instr();
    `CHK(rww_read_ok_o, 1'b0)
    `CHK(cpu_halt_o, halt)
    `CHK(no_read_while_write_section_read_ok_o, ~halt)
    repeat (OP) @(posedge clk_i);
    `CHK(rww_read_ok_o, 1'b0)
    rdchk(8'h10, 32'h1);
    wb(1'b1, 8'h14, 32'h7);
    `CHK(irq_o, 1'b1)
    wb(1'b1, 8'h14, 32'h0);
    `CHK(irq_o, 1'b0)
    wb(1'b1, 8'h10, 32'h7);
    rdchk(8'h10, 32'h0);
    wb(1'b1, 8'h00, 32'h10);
    `CHK(rww_read_ok_o, 1'b1)
  endtask
  task automatic t_eeprom;
    eeprom_busy_i <= 1'b1;
    wb(1'b1, 8'h00, 32'h05);
    rdchk(8'h00, 32'h0);
    rdchk(8'h18, 32'h0);
    rdchk(8'h1C, 32'h0);
    store_program_instr();
    `CHK(rww_read_ok_o, 1'b1)
    eeprom_busy_i <= 1'b0;
    wb(1'b1, 8'h10, 32'h7);
  endtask
  task automatic t_lock;
    wb(1'b1, 8'h04, 32'h1);
    wb(1'b1, 8'h08, 32'hEF);
    wb(1'b1, 8'h00, 32'h09);
    store_program_instr();
    waited = 0;
    while (lock_bits_o === 8'hFF && waited < 800) begin
      @(posedge clk_i);
      waited++;
    end
    @(posedge clk_i);
    rdchk(8'h18, 32'hEF);
    wb(1'b1, 8'h10, 32'h7);
    wb(1'b1, 8'h04, {17'h0, 8'hF2, 7'h0});
    wb(1'b1, 8'h00, 32'h05);
    store_program_instr();
    `CHK(rww_read_ok_o, 1'b1)
    rdchk(8'h10, 32'h2);
    wb(1'b1, 8'h10, 32'h7);
  endtask
  task automatic t_fuse;
    u_pp.write_fuse(8'hA5, waited);
    `CHK(waited > 500, 1'b1)
    `CHK(fuse_high_o, 8'hA5)
    rdchk(8'h1C, 32'hA5);
    rdchk(8'h10, 32'h4);
  endtask
  // ============================================================
  // Run control
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_spm_irq();
    t_page(8'h10, 1'b0);
    t_page(8'hE4, 1'b1);
    t_eeprom();
    t_lock();
    t_fuse();
    finish_test();
  end
  // Whole run needs about 1300 cycles
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
endmodule
